// ===== dv/shamc_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
module shamc_bus_master (
   input  wire logic       ref_clk,
   input  wire logic       txValid,
   input  wire logic [7:0] txByte,
   output var logic        cmdStart,
   output var logic [7:0]  cmdCode,
   output var logic        rxValid,
   output var logic [7:0]  rxByte,
   output var logic        txReq
);
   // ---------------------------------
   // Master side transfers
   // ---------------------------------
   int gap = 0;

   initial begin
      cmdStart = 1'b0;
      cmdCode  = 8'h00;
      rxValid  = 1'b0;
      rxByte   = 8'h00;
      txReq    = 1'b0;
   end

   // Extra idle cycles model a slow master
   task automatic put(input logic [7:0] b);
      repeat (gap) @(negedge ref_clk);
      @(negedge ref_clk);
      rxValid = 1'b1;
      rxByte  = b;
      @(negedge ref_clk);
      rxValid = 1'b0;
      rxByte  = ~b;
   endtask

   task automatic command(input logic [7:0] c, input logic [15:0] ta);
      @(negedge ref_clk);
      cmdStart = 1'b1;
      cmdCode  = c;
      @(negedge ref_clk);
      cmdStart = 1'b0;
      cmdCode  = ~c;
      put(ta[7:0]);
      put(ta[15:8]);
   endtask

   // Returns at the earliest two cycles apart
   task automatic fetch(output logic [7:0] b, output logic ok);
      int i;
      @(negedge ref_clk);
      txReq = 1'b1;
      @(negedge ref_clk);
      txReq = 1'b0;
      ok = 1'b0;
      b = 8'h00;
      for (i = 0; i < 3 && !ok; i++) begin
         if (txValid === 1'b1) begin
            ok = 1'b1;
            b = txByte;
         end else begin
            @(negedge ref_clk);
         end
      end
   endtask
endmodule
`default_nettype wire

// ===== dv/shamc_core_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module shamc_core_monitor (
   input wire logic         ref_clk,
   input wire logic         rstn,
   input wire logic         rxValid,
   input wire logic         txReq,
   input wire logic         txValid,
   input wire logic [7:0]   txByte,
   input wire logic         lfsEnable,
   input wire logic [15:0]  targetAddr,
   input wire logic [63:0]  spData,
   input wire logic         shaStart,
   input wire logic         shaNextSecret,
   input wire logic         shaBusy,
   input wire logic         macValid,
   input wire logic [159:0] mac
);
   // ---------------------------------
   // Port relations
   // ---------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   a_tx_answer: assert property (txValid |-> $past(txReq))
      else $error("read byte without request");
   a_busy_rise: assert property (shaStart && !shaBusy |=> shaBusy)
      else $error("hash start not taken");
   a_mac_delay: assert property (
      shaStart && !shaBusy && !shaNextSecret |-> ##81 macValid)
      else $error("mac not ready on time");
   a_secret_len: assert property (
      shaStart && !shaBusy && shaNextSecret |-> ##88 shaBusy ##1 !shaBusy)
      else $error("next secret length wrong");
   a_mac_steady: assert property ($changed(mac) |-> macValid)
      else $error("mac moved without valid");
   a_flag_set: assert property ($rose(lfsEnable) |-> $past(rxValid, 2))
      else $error("flag rose without last byte");
   a_secret_hide: assert property (
      txValid && targetAddr[15:3] == 13'h0010 |-> txByte == 8'hff)
      else $error("secret byte exposed");
   a_sp_frozen: assert property (txValid |-> $stable(spData))
      else $error("scratchpad moved during read");
   a_flag_read: assert property (txValid |-> !lfsEnable)
      else $error("flag still set while reading");
endmodule

bind shamc_core shamc_core_monitor mon_u (
   .ref_clk(ref_clk), .rstn(rstn), .rxValid(rxValid), .txReq(txReq),
   .txValid(txValid), .txByte(txByte), .lfsEnable(lfsEnable),
   .targetAddr(targetAddr), .spData(spData), .shaStart(shaStart),
   .shaNextSecret(shaNextSecret), .shaBusy(shaBusy),
   .macValid(macValid), .mac(mac)
);
`default_nettype wire

// ===== dv/tb_shamc_core.sv
`timescale 1ns/10ps
`default_nettype none
module tb_shamc_core;
   logic         ref_clk = 1'b0;
   logic         rstn = 1'b0;
   logic         cmdStart, rxValid, txReq, txValid, lfsEnable;
   logic [7:0]   cmdCode, rxByte, txByte;
   logic         msgWe = 1'b0, shaStart = 1'b0, shaNextSecret = 1'b0;
   logic         loadWe = 1'b0, shaBusy, macValid;
   logic [7:0]   loadAddr = 8'h00, loadData = 8'h00;
   logic [3:0]   msgIdx = 4'h0;
   logic [31:0]  msgWord = 32'h00000000;
   logic [15:0]  targetAddr;
   logic [63:0]  spData;
   logic [159:0] mac;
   int           error_cnt = 0;
   int           checks = 0;

   always #25 ref_clk = ~ref_clk;

   shamc_core dut_u (
      .ref_clk(ref_clk), .rstn(rstn), .cmdStart(cmdStart),
      .cmdCode(cmdCode), .rxValid(rxValid), .rxByte(rxByte),
      .txReq(txReq), .txValid(txValid), .txByte(txByte),
      .lfsEnable(lfsEnable), .targetAddr(targetAddr), .spData(spData),
      .msgWe(msgWe), .msgIdx(msgIdx), .msgWord(msgWord),
      .shaStart(shaStart), .shaNextSecret(shaNextSecret),
      .shaBusy(shaBusy), .macValid(macValid), .mac(mac),
      .loadWe(loadWe), .loadAddr(loadAddr), .loadData(loadData)
   );

   shamc_bus_master mp (
      .ref_clk(ref_clk), .txValid(txValid), .txByte(txByte),
      .cmdStart(cmdStart), .cmdCode(cmdCode), .rxValid(rxValid),
      .rxByte(rxByte), .txReq(txReq)
   );

   // ---------------------------------
   // Helpers
   // ---------------------------------
   task automatic results();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [159:0] seen,
                        input logic [159:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [7:0] memv(input logic [15:0] a);
      return a[7:0] ^ 8'h3c;
   endfunction

   // Page packet check word, as a careful master keeps it
   function automatic logic [15:0] crc16(input logic [15:0] c,
                                         input logic [7:0] d);
      logic [15:0] r;
      int j;
      r = c ^ {8'h00, d};
      for (j = 0; j < 8; j++)
         r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
      return r;
   endfunction

   function automatic logic [63:0] row(input logic [15:0] t);
      int i;
      for (i = 0; i < 8; i++)
         row[63-8*i -: 8] = memv({t[15:3], 3'h0} + 16'(i));
   endfunction

   // Own reference: no add-back of the start values
   function automatic logic [159:0] sha_ref(input logic [511:0] m);
      logic [31:0] w [0:79];
      logic [31:0] a, b, c, d, e, f, k, t;
      int i;
      a = 32'h67452301;
      b = 32'hefcdab89;
      c = 32'h98badcfe;
      d = 32'h10325476;
      e = 32'hc3d2e1f0;
      for (i = 0; i < 80; i++) begin
         if (i < 16) begin
            w[i] = m[511-32*i -: 32];
         end else begin
            t = w[i-3] ^ w[i-8] ^ w[i-14] ^ w[i-16];
            w[i] = {t[30:0], t[31]};
         end
      end
      for (i = 0; i < 80; i++) begin
         if (i < 20) begin
            f = (b & c) | (~b & d);
            k = 32'h5a827999;
         end else if (i < 40) begin
            f = b ^ c ^ d;
            k = 32'h6ed9eba1;
         end else if (i < 60) begin
            f = (b & c) | (b & d) | (c & d);
            k = 32'h8f1bbcdc;
         end else begin
            f = b ^ c ^ d;
            k = 32'hca62c1d6;
         end
         t = {a[26:0], a[31:27]} + f + w[i] + k + e;
         e = d;
         d = c;
         c = {b[1:0], b[31:2]};
         b = a;
         a = t;
      end
      return {a, b, c, d, e};
   endfunction

   task automatic wait_idle();
      int i;
      for (i = 0; shaBusy !== 1'b0; i++) begin
         if (i > 200) begin
            error_cnt++;
            results();
         end
         @(negedge ref_clk);
      end
   endtask

   // ---------------------------------
   // Scenarios
   // ---------------------------------
   task automatic refresh_row();
      mp.command(8'ha3, 16'h0012);
      @(negedge ref_clk);
      check("flag", lfsEnable, 0);
      repeat (8) mp.put(8'h5a);
      repeat (3) @(negedge ref_clk);
      check("flag", lfsEnable, 1);
      check("scratch", spData, row(16'h0012));
   endtask

   task automatic read_run(input logic [15:0] t, input int n);
      logic [7:0] b;
      logic ok;
      logic [15:0] a;
      logic [63:0] sp;
      logic [7:0] e;
      logic [15:0] crcSeen, crcExp;
      int i;
      mp.command(8'hf0, t);
      @(negedge ref_clk);
      check("flag", lfsEnable, 0);
      sp = spData;
      crcSeen = 16'h0000;
      crcExp = 16'h0000;
      for (i = 0; i < n; i++) begin
         a = t + 16'(i);
         mp.fetch(b, ok);
         if (!ok) begin
            error_cnt++;
            results();
         end
         e = (a[15:3] == 13'h0010 || a > 16'h0097) ? 8'hff : memv(a);
         check("byte", b, e);
         crcSeen = crc16(crcSeen, b);
         crcExp = crc16(crcExp, e);
         if (a <= 16'h0097)
            check("target", targetAddr, a);
      end
      check("page crc", crcSeen, crcExp);
      check("scratch", spData, sp);
   endtask

   // Every other clearing command after a flag-setting refresh
   task automatic flag_clears();
      logic [23:0] codes;
      int i;
      codes = {8'h01, 8'h02, 8'ha5};
      for (i = 0; i < 3; i++) begin
         refresh_row();
         mp.command(codes[23-8*i -: 8], 16'h0040);
         @(negedge ref_clk);
         check("flag", lfsEnable, 0);
      end
   endtask

   task automatic load_msg(input logic [511:0] m);
      int i;
      for (i = 0; i < 16; i++) begin
         @(negedge ref_clk);
         msgWe = 1'b1;
         msgIdx = 4'(i);
         msgWord = m[511-32*i -: 32];
      end
      @(negedge ref_clk);
      msgWe = 1'b0;
   endtask

   // Bytes past offset 7 must be dropped
   task automatic refresh_secret();
      logic [63:0] exp;
      logic [7:0] v;
      exp = row(16'h0012);
      exp[31:0] = 32'hc4c5c6c7;
      mp.gap = 3;
      mp.command(8'ha3, 16'h0084);
      for (v = 8'hc4; v < 8'hca; v++)
         mp.put(v);
      mp.gap = 0;
      repeat (3) @(negedge ref_clk);
      check("flag", lfsEnable, 0);
      check("scratch", spData, exp);
   endtask

   task automatic hash_run();
      logic [511:0] m;
      logic [159:0] exp;
      int i;
      m = '0;
      m[511:480] = 32'h61626380;
      m[31:0] = 32'h00000018;
      load_msg(m);
      shaStart = 1'b1;
      @(negedge ref_clk);
      shaStart = 1'b0;
      check("busy", shaBusy, 1);
      for (i = 0; macValid !== 1'b1; i++) begin
         if (i > 200) begin
            error_cnt++;
            results();
         end
         @(negedge ref_clk);
      end
      exp = sha_ref(m);
      check("mac", mac, exp);
      wait_idle();
      load_msg(m);
      shaStart = 1'b1;
      shaNextSecret = 1'b1;
      @(negedge ref_clk);
      shaStart = 1'b0;
      shaNextSecret = 1'b0;
      @(negedge ref_clk);
      wait_idle();
      check("mac", mac, exp);
      for (i = 0; i < 8; i++)
         check("secret", dut_u.uMem.memArray[128+i], exp[63-8*i -: 8]);
   endtask

   initial begin
      #2000000;
      error_cnt++;
      results();
   end

   initial begin
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      rstn = 1'b1;
      check("flag", lfsEnable, 0);
      check("busy", shaBusy, 0);
      for (int a = 0; a < 152; a++) begin
         @(negedge ref_clk);
         loadWe = 1'b1;
         loadAddr = 8'(a);
         loadData = memv(16'(a));
      end
      @(negedge ref_clk);
      loadWe = 1'b0;
      refresh_row();
      read_run(16'h0085, 4);
      read_run(16'h0096, 3);
      refresh_row();
      refresh_secret();
      flag_clears();
      hash_run();
      results();
   end
endmodule
`default_nettype wire

// ===== hdl/shamc_core.v
`timescale 1ns/10ps
`default_nettype none
`include "shamc_defines.vh"

module shamc_core #(
   parameter [7:0] CMD_WRITE_SP    = 8'h01,
   parameter [7:0] CMD_NEXT_SECRET = 8'h02
) (
   input  wire         ref_clk,
   input  wire         rstn,
   input  wire         cmdStart,
   input  wire [7:0]   cmdCode,
   input  wire         rxValid,
   input  wire [7:0]   rxByte,
   input  wire         txReq,
   output wire         txValid,
   output wire [7:0]   txByte,
   output wire         lfsEnable,
   output wire [15:0]  targetAddr,
   output wire [63:0]  spData,
   input  wire         msgWe,
   input  wire [3:0]   msgIdx,
   input  wire [31:0]  msgWord,
   input  wire         shaStart,
   input  wire         shaNextSecret,
   output wire         shaBusy,
   output wire         macValid,
   output wire [159:0] mac,
   input  wire         loadWe,
   input  wire [7:0]   loadAddr,
   input  wire [7:0]   loadData
);

   // ---------------------------------------------------------
   // States
   // ---------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_TA1  = 3'h1;
   localparam [2:0] ST_TA2  = 3'h2;
   localparam [2:0] ST_WRSP = 3'h3;
   localparam [2:0] ST_REFR = 3'h4;
   localparam [2:0] ST_READ = 3'h5;
   localparam [2:0] ST_SINK = 3'h6;

   // ---------------------------------------------------------
   // Functions
   // ---------------------------------------------------------
   function [31:0] rotl;
      input [31:0] x;
      input integer n;
      begin
         rotl = (x << n) | (x >> (32 - n));
      end
   endfunction

   function [31:0] roundF;
      input [6:0]  t;
      input [31:0] b;
      input [31:0] c;
      input [31:0] d;
      begin
         if (t <= `SHAMC_GRP1_LAST) begin
            roundF = (b & c) | (~b & d);
         end else if (t <= `SHAMC_GRP2_LAST) begin
            roundF = b ^ c ^ d;
         end else if (t <= `SHAMC_GRP3_LAST) begin
            roundF = (b & c) | (b & d) | (c & d);
         end else begin
            roundF = b ^ c ^ d;
         end
      end
   endfunction

   function [31:0] roundK;
      input [6:0] t;
      begin
         if (t <= `SHAMC_GRP1_LAST) begin
            roundK = `SHAMC_K0;
         end else if (t <= `SHAMC_GRP2_LAST) begin
            roundK = `SHAMC_K1;
         end else if (t <= `SHAMC_GRP3_LAST) begin
            roundK = `SHAMC_K2;
         end else begin
            roundK = `SHAMC_K3;
         end
      end
   endfunction

   // Secret bytes never leave through read memory
   function readable;
      input [15:0] a;
      begin
         readable = (a <= `SHAMC_LAST_ADDR) &&
                    !((a >= `SHAMC_SECRET_BASE) &&
                      (a < `SHAMC_REGPAGE_BASE));
      end
   endfunction

   // ---------------------------------------------------------
   // Command state
   // ---------------------------------------------------------
   reg  [2:0]  state_q;
   reg  [7:0]  cmd_q;
   reg  [15:0] target_q;
   reg  [15:0] cur_q;
   reg  [2:0]  spIdx_q;
   reg         pend_q;
   reg  [2:0]  pendIdx_q;
   reg         lfs_q;
   reg         txValid_q;
   reg  [7:0]  txByte_q;
   reg  [7:0]  sp_q [0:7];
   wire [7:0]  memRd;
   wire [7:0]  memRdAddr;
   wire [15:0] fullAddr;
   wire        clearsLfs;

   assign fullAddr  = {rxByte, target_q[7:0]};
   assign clearsLfs = (cmd_q == CMD_WRITE_SP) ||
                      (cmd_q == CMD_NEXT_SECRET) ||
                      (cmd_q == `SHAMC_CMD_READ_AUTH) ||
                      (cmd_q == `SHAMC_CMD_REFRESH) ||
                      (cmd_q == `SHAMC_CMD_READ_MEM);
   assign memRdAddr = (state_q == ST_READ) ? cur_q[7:0] :
                      {target_q[7:3], spIdx_q};

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_q   <= ST_IDLE;
         cmd_q     <= 8'h00;
         target_q  <= 16'h0000;
         cur_q     <= 16'h0000;
         spIdx_q   <= 3'h0;
         pend_q    <= 1'b0;
         pendIdx_q <= 3'h0;
         lfs_q     <= 1'b0;
         txValid_q <= 1'b0;
         txByte_q  <= 8'h00;
      end else begin
         txValid_q <= 1'b0;
         pend_q    <= 1'b0;
         if (cmdStart) begin
            cmd_q   <= cmdCode;
            state_q <= ST_TA1;
         end else begin
            case (state_q)
               ST_TA1: begin
                  if (rxValid) begin
                     target_q[7:0] <= rxByte;
                     state_q       <= ST_TA2;
                  end
               end
               ST_TA2: begin
                  if (rxValid) begin
                     target_q <= fullAddr;
                     cur_q    <= fullAddr;
                     spIdx_q  <= fullAddr[2:0];
                     if (clearsLfs) begin
                        lfs_q <= 1'b0;
                     end
                     if (cmd_q == `SHAMC_CMD_READ_MEM) begin
                        state_q <= ST_READ;
                     end else if ((cmd_q == `SHAMC_CMD_REFRESH) &&
                                  (fullAddr <= `SHAMC_DATA_END)) begin
                        spIdx_q <= 3'h0;
                        state_q <= ST_REFR;
                     end else if ((cmd_q == `SHAMC_CMD_REFRESH) ||
                                  (cmd_q == CMD_WRITE_SP)) begin
                        state_q <= ST_WRSP;
                     end else begin
                        state_q <= ST_SINK;
                     end
                  end
               end
               ST_WRSP: begin
                  if (rxValid) begin
                     spIdx_q <= spIdx_q + 3'h1;
                     if (spIdx_q == `SHAMC_SP_LAST) begin
                        state_q <= ST_SINK;
                     end
                  end
               end
               ST_REFR: begin
                  // Received byte only paces the fill
                  if (rxValid) begin
                     pend_q    <= 1'b1;
                     pendIdx_q <= spIdx_q;
                     spIdx_q   <= spIdx_q + 3'h1;
                     if (spIdx_q == `SHAMC_SP_LAST) begin
                        state_q <= ST_SINK;
                     end
                  end
               end
               ST_READ: begin
                  if (txReq) begin
                     txValid_q <= 1'b1;
                     txByte_q  <= readable(cur_q) ? memRd :
                                  `SHAMC_ALL_ONES;
                     target_q  <= cur_q;
                     cur_q     <= cur_q + 16'h0001;
                  end
               end
               ST_SINK: begin
                  state_q <= ST_SINK;
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
         // Set beats a same-cycle clear
         if (pend_q && (pendIdx_q == `SHAMC_SP_LAST)) begin
            lfs_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------
   // Scratchpad
   // ---------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : gSp
         always @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               sp_q[g] <= 8'h00;
            end else if (pend_q && (pendIdx_q == g)) begin
               sp_q[g] <= memRd;
            end else if ((state_q == ST_WRSP) && rxValid &&
                         !cmdStart && (spIdx_q == g)) begin
               sp_q[g] <= rxByte;
            end
         end
         assign spData[63-8*g -: 8] = sp_q[g];
      end
   endgenerate

   // ---------------------------------------------------------
   // Hash engine
   // ---------------------------------------------------------
   reg  [31:0] w_q [0:15];
   reg  [31:0] a_q;
   reg  [31:0] b_q;
   reg  [31:0] c_q;
   reg  [31:0] d_q;
   reg  [31:0] e_q;
   reg  [6:0]  t_q;
   reg         busy_q;
   reg         shaBusy_q;
   reg         nextSec_q;
   reg         macValid_q;
   reg  [159:0] mac_q;
   reg         wb_q;
   reg  [2:0]  wbCnt_q;
   reg  [63:0] wbData_q;
   wire [3:0]  slot;
   wire [31:0] wNew;
   wire [31:0] wCur;
   wire [31:0] tmp;

   assign slot = t_q[3:0];
   assign wNew = rotl(w_q[slot + 4'hd] ^ w_q[slot + 4'h8] ^
                      w_q[slot + 4'h2] ^ w_q[slot],
                      `SHAMC_ROT_W);
   assign wCur = (t_q < `SHAMC_SCHED_START) ? w_q[slot] : wNew;
   assign tmp  = rotl(a_q, `SHAMC_ROT_A) + roundF(t_q, b_q, c_q, d_q) +
                 wCur + roundK(t_q) + e_q;

   generate
      for (g = 0; g < 16; g = g + 1) begin : gW
         always @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               w_q[g] <= 32'h00000000;
            end else if (!busy_q && msgWe && (msgIdx == g)) begin
               w_q[g] <= msgWord;
            end else if (busy_q && (slot == g)) begin
               w_q[g] <= wCur;
            end
         end
      end
   endgenerate

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         a_q        <= 32'h00000000;
         b_q        <= 32'h00000000;
         c_q        <= 32'h00000000;
         d_q        <= 32'h00000000;
         e_q        <= 32'h00000000;
         t_q        <= 7'h00;
         busy_q     <= 1'b0;
         shaBusy_q  <= 1'b0;
         nextSec_q  <= 1'b0;
         macValid_q <= 1'b0;
         mac_q      <= 160'h0;
         wb_q       <= 1'b0;
         wbCnt_q    <= 3'h0;
         wbData_q   <= 64'h0;
      end else begin
         macValid_q <= 1'b0;
         if (shaStart && !busy_q && !wb_q) begin
            a_q       <= `SHAMC_H0;
            b_q       <= `SHAMC_H1;
            c_q       <= `SHAMC_H2;
            d_q       <= `SHAMC_H3;
            e_q       <= `SHAMC_H4;
            t_q       <= 7'h00;
            busy_q    <= 1'b1;
            shaBusy_q <= 1'b1;
            nextSec_q <= shaNextSecret;
         end else if (busy_q) begin
            a_q <= tmp;
            b_q <= a_q;
            c_q <= rotl(b_q, `SHAMC_ROT_B);
            d_q <= c_q;
            e_q <= d_q;
            t_q <= t_q + 7'h01;
            if (t_q == `SHAMC_LAST_ROUND) begin
               busy_q <= 1'b0;
               if (nextSec_q) begin
                  // Final D is the old C; final E is the old D
                  wb_q     <= 1'b1;
                  wbCnt_q  <= 3'h0;
                  wbData_q <= {c_q, d_q};
               end else begin
                  // No initial-value add back, unlike the full hash
                  mac_q      <= {tmp, a_q, rotl(b_q, `SHAMC_ROT_B),
                                 c_q, d_q};
                  macValid_q <= 1'b1;
                  shaBusy_q  <= 1'b0;
               end
            end
         end else if (wb_q) begin
            wbCnt_q  <= wbCnt_q + 3'h1;
            wbData_q <= {wbData_q[55:0], 8'h00};
            if (wbCnt_q == `SHAMC_SP_LAST) begin
               wb_q      <= 1'b0;
               shaBusy_q <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------
   // Memory; secret write-back takes the write port first
   // ---------------------------------------------------------
   wire       memWe;
   wire [7:0] memWrAddr;
   wire [7:0] memWrData;
   wire [15:0] secretBase;

   assign secretBase = `SHAMC_SECRET_BASE;
   assign memWe      = wb_q | loadWe;
   assign memWrAddr  = wb_q ? (secretBase[7:0] + {5'h00, wbCnt_q}) :
                       loadAddr;
   assign memWrData  = wb_q ? wbData_q[63:56] : loadData;

   shamc_mem #(
      .ADDR_W (8),
      .DEPTH  (`SHAMC_MEM_DEPTH)
   ) uMem (
      .ref_clk (ref_clk),
      .wrEn    (memWe),
      .wrAddr  (memWrAddr),
      .wrData  (memWrData),
      .rdAddr  (memRdAddr),
      .rdData  (memRd)
   );

   // ---------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------
   assign txValid    = txValid_q;
   assign txByte     = txByte_q;
   assign lfsEnable  = lfs_q;
   assign targetAddr = target_q;
   assign shaBusy    = shaBusy_q;
   assign macValid   = macValid_q;
   assign mac        = mac_q;

endmodule

`default_nettype wire

// ===== hdl/shamc_mem.v
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Byte memory, registered read
// ------------------------------------------------------------
module shamc_mem #(
   parameter ADDR_W = 8,
   parameter DEPTH  = 152
) (
   input  wire              ref_clk,
   input  wire              wrEn,
   input  wire [ADDR_W-1:0] wrAddr,
   input  wire [7:0]        wrData,
   input  wire [ADDR_W-1:0] rdAddr,
   output reg  [7:0]        rdData
);

   reg [7:0] memArray [0:DEPTH-1];

   always @(posedge ref_clk) begin
      if (wrEn) begin
         memArray[wrAddr] <= wrData;
      end
      rdData <= memArray[rdAddr];
   end

endmodule

`default_nettype wire

// ===== pkg/shamc_defines.vh
`ifndef SHAMC_DEFINES_VH
`define SHAMC_DEFINES_VH

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define SHAMC_CMD_REFRESH   8'ha3
`define SHAMC_CMD_READ_MEM  8'hf0
`define SHAMC_CMD_READ_AUTH 8'ha5

// ------------------------------------------------------------
// Memory map
// ------------------------------------------------------------
`define SHAMC_DATA_END      16'h007f
`define SHAMC_SECRET_BASE   16'h0080
`define SHAMC_REGPAGE_BASE  16'h0088
`define SHAMC_REGPAGE_END   16'h008f
`define SHAMC_LAST_ADDR     16'h0097
`define SHAMC_MEM_DEPTH     152
`define SHAMC_ALL_ONES      8'hff
`define SHAMC_SP_LAST       3'h7

// ------------------------------------------------------------
// Hash constants
// ------------------------------------------------------------
`define SHAMC_K0            32'h5a827999
`define SHAMC_K1            32'h6ed9eba1
`define SHAMC_K2            32'h8f1bbcdc
`define SHAMC_K3            32'hca62c1d6
`define SHAMC_H0            32'h67452301
`define SHAMC_H1            32'hefcdab89
`define SHAMC_H2            32'h98badcfe
`define SHAMC_H3            32'h10325476
`define SHAMC_H4            32'hc3d2e1f0
`define SHAMC_GRP1_LAST     7'h13
`define SHAMC_GRP2_LAST     7'h27
`define SHAMC_GRP3_LAST     7'h3b
`define SHAMC_LAST_ROUND    7'h4f
`define SHAMC_SCHED_START   7'h10
`define SHAMC_ROT_A         5
`define SHAMC_ROT_B         30
`define SHAMC_ROT_W         1

`endif
